// ===== hw/rhc_consts.vh
`ifndef RHC_CONSTS_VH
`define RHC_CONSTS_VH

// APB register offsets
`define RHC_OFS_CTRL 8'h00
`define RHC_OFS_CFG 8'h04
`define RHC_OFS_TLO 8'h08
`define RHC_OFS_THI 8'h0C
`define RHC_OFS_ALO 8'h10
`define RHC_OFS_AHI 8'h14
`define RHC_OFS_STAT 8'h18

// CTRL bits: 0..4 are self-clearing commands
`define RHC_C_INIT 0
`define RHC_C_SET 1
`define RHC_C_READ 2
`define RHC_C_ALM 3
`define RHC_C_CLR 4
`define RHC_C_CMDS 4:0
`define RHC_C_AUTO 5
`define RHC_C_DROP_MON 6
`define RHC_C_GATE 7

// CFG fields
`define RHC_F_CT 2:0
`define RHC_F_CLEN2 4
`define RHC_F_ADJ 15:8
`define RHC_F_CLEN1 16
`define RHC_F_WEN 17
`define RHC_F_DEN 18
`define RHC_F_CLRW 19
`define RHC_F_CLRD 20
`define RHC_CFG_W 21
`define RHC_CFG_RST 21'h000000

// STATUS bits
`define RHC_S_BUSY 0
`define RHC_S_RDY 1
`define RHC_S_POWER_ON_FLAG 2
`define RHC_S_NACK 3
`define RHC_S_LATE 4
`define RHC_S_FULL 5
`define RHC_S_IRQA 6
`define RHC_S_IRQB 7

// Clock register indices and bit positions
`define RHC_R_SEC 4'h0
`define RHC_R_ADJ 4'h7
`define RHC_R_ALW 4'h8
`define RHC_R_CTL1 4'hE
`define RHC_R_CTL2 4'hF
`define RHC_LEN_FULL 3'h7
`define RHC_LEN_RED 3'h5
`define RHC_LEN_ALM 3'h5
`define RHC_LEN_ONE 3'h1
`define RHC_B1_WEEKLY_ALARM_ENABLE 7
`define RHC_B1_DAILY_ALARM_ENABLE 6
`define RHC_B1_POWER_ON_FLAG 5
`define RHC_B1_CLEN2 4
`define RHC_B2_SUPPLY_DROP_FLAG 6
`define RHC_B2_CLEN1 3
`define RHC_B2_PERIODIC_IRQ_FLAG 2
`define RHC_B2_WEEKLY_ALARM_FLAG 1
`define RHC_B2_DAILY_ALARM_FLAG 0

// Byte engine commands
`define RHC_E_START 2'h0
`define RHC_E_STOP 2'h1
`define RHC_E_WR 2'h2
`define RHC_E_RD 2'h3

// Timing
// Two seconds and half a second of the 100 MHz clock
`define RHC_PWR_WAIT_CYC 28'hBEBC200
`define RHC_LIMIT_CYC 28'h2FAF080
`define RHC_SCL_QTR 16'h00FA

`endif

// ===== hw/rhc_sync.v
`timescale 1ns/100ps
module rhc_sync #(
  parameter W = 3
) (
  // Clock and reset
  input wire clock_in,
  input wire rst_b_in,
  // Asynchronous levels and their synchronised copies
  input wire [W-1:0] d_in,
  output wire [W-1:0] q_out
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg meta_reg;
      reg sync_reg;
      // Idle level of every pulled-up line is high
      always @(posedge clock_in) begin
        if (!rst_b_in) begin
          meta_reg <= 1'b1;
          sync_reg <= 1'b1;
        end else begin
          meta_reg <= d_in[i];
          sync_reg <= meta_reg;
        end
      end
      assign q_out[i] = sync_reg;
    end
  endgenerate
endmodule

// ===== hw/rhc_i2c_byte.v
`timescale 1ns/100ps
`include "rhc_consts.vh"
module rhc_i2c_byte #(
  parameter [15:0] QTR = `RHC_SCL_QTR
) (
  // Clock and reset
  input wire clock_in,
  input wire rst_b_in,
  // Command side
  input wire go_in,
  input wire [1:0] cmd_in,
  input wire [7:0] wdata_in,
  input wire nack_in,
  output wire done_out,
  output wire ack_err_out,
  output wire [7:0] rdata_out,
  // Bus side, sda_in already synchronised
  input wire sda_in,
  output wire scl_oe_out,
  output wire sda_oe_out
);
  localparam [15:0] QTR_M1 = QTR - 16'h0001;
  reg busy_reg;
  reg done_reg;
  reg err_reg;
  reg nack_reg;
  reg [1:0] cmd_reg;
  reg [1:0] phase_reg;
  reg [15:0] tick_reg;
  reg [3:0] bit_reg;
  reg [7:0] shift_reg;
  reg scl_oe_reg;
  reg sda_oe_reg;
  wire ack_slot = (bit_reg == 4'h8);
  wire data_drive = ack_slot ? ((cmd_reg == `RHC_E_RD) & ~nack_reg)
                             : ((cmd_reg == `RHC_E_WR) & ~shift_reg[7]);

  always @(posedge clock_in) begin
    if (!rst_b_in) begin
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      err_reg <= 1'b0;
      nack_reg <= 1'b0;
      cmd_reg <= `RHC_E_STOP;
      phase_reg <= 2'h0;
      tick_reg <= 16'h0000;
      bit_reg <= 4'h0;
      shift_reg <= 8'h00;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (!busy_reg) begin
        if (go_in) begin
          busy_reg <= 1'b1;
          cmd_reg <= cmd_in;
          shift_reg <= wdata_in;
          nack_reg <= nack_in;
          err_reg <= 1'b0;
          phase_reg <= 2'h0;
          tick_reg <= 16'h0000;
          bit_reg <= 4'h0;
        end
      end else if (tick_reg != QTR_M1) begin
        tick_reg <= tick_reg + 16'h0001;
      end else begin
        tick_reg <= 16'h0000;
        phase_reg <= phase_reg + 2'h1;
        case (phase_reg)
          2'h0: begin
            // Data changes only while the clock is low
            if (cmd_reg == `RHC_E_START)
              sda_oe_reg <= 1'b0;
            else if (cmd_reg == `RHC_E_STOP)
              sda_oe_reg <= 1'b1;
            else
              sda_oe_reg <= data_drive;
          end
          2'h1: scl_oe_reg <= 1'b0;
          2'h2: begin
            if (cmd_reg == `RHC_E_START)
              sda_oe_reg <= 1'b1;
            else if (cmd_reg == `RHC_E_STOP)
              sda_oe_reg <= 1'b0;
            else if (ack_slot)
              err_reg <= (cmd_reg == `RHC_E_WR) & sda_in;
            else
              shift_reg <= {shift_reg[6:0], sda_in};
          end
          default: begin
            if (cmd_reg != `RHC_E_STOP)
              scl_oe_reg <= 1'b1;
            if (cmd_reg == `RHC_E_START || cmd_reg == `RHC_E_STOP || ack_slot) begin
              busy_reg <= 1'b0;
              done_reg <= 1'b1;
            end else begin
              bit_reg <= bit_reg + 4'h1;
            end
          end
        endcase
      end
    end
  end

  assign done_out = done_reg;
  assign ack_err_out = err_reg;
  assign rdata_out = shift_reg;
  assign scl_oe_out = scl_oe_reg;
  assign sda_oe_out = sda_oe_reg;
endmodule

// ===== hw/rhc_host.v
// Overview of operation
// - After power-up wait about two seconds before any access to the clock.
// - With supply monitoring, clear the supply-drop flag once after each seconds write.
// - Set time: seconds through year in one transfer, no stop before year.
// - Each counter access, start to stop, ends within half a second.
// - Read time: seconds through year in one continuous transfer.
// - Interrupt reading uses level mode; read completes within half a second.
// - After each periodic interrupt write 0 to the periodic flag.
// - Read all counters only in the first interrupt session after setting time.
// - Clear alarm enables before loading new alarm times.
// - Set alarm enables only after every alarm time register is written.
// - Disable the crystal clock output before the attached device powers down.
// - Initialisation programs oscillation adjustment and periodic interrupt select.
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/100ps
`include "rhc_consts.vh"
module rhc_host #(
  parameter [27:0] PWR_WAIT_CYC = `RHC_PWR_WAIT_CYC,
  parameter [27:0] LIMIT_CYC = `RHC_LIMIT_CYC,
  parameter [15:0] SCL_QTR = `RHC_SCL_QTR,
  parameter [6:0] DEV_ADDR = 7'h30 // Arbitrary bus address
) (
  // Clock and reset
  input wire clock_in,
  input wire rst_b_in,
  // APB slave
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [7:0] paddr_in,
  input wire [31:0] pwdata_in,
  output wire pready_out,
  output wire [31:0] prdata_out,
  output wire pslverr_out,
  // Two-wire bus, open drain
  output wire scl_out,
  output wire scl_oe_out,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe_out,
  // Clock interrupt lines and clock-output gate
  input wire irq_out_a_n_in,
  input wire irq_out_b_n_in,
  output wire clock_out_gate_pin_out
);
  localparam [2:0] J_NONE = 3'h0;
  localparam [2:0] J_INIT = 3'h1;
  localparam [2:0] J_SET = 3'h2;
  localparam [2:0] J_READ = 3'h3;
  localparam [2:0] J_SVC = 3'h4;
  localparam [2:0] J_ALM = 3'h5;
  localparam [2:0] J_CLR = 3'h6;
  localparam [2:0] X_START = 3'h0;
  localparam [2:0] X_ADDRW = 3'h1;
  localparam [2:0] X_PTR = 3'h2;
  localparam [2:0] X_RST = 3'h3;
  localparam [2:0] X_ADDRR = 3'h4;
  localparam [2:0] X_DATA = 3'h5;
  localparam [2:0] X_STOP = 3'h6;
  localparam [2:0] X_END = 3'h7;

  reg pready_reg;
  reg pslverr_reg;
  reg [31:0] prdata_reg;
  reg [31:0] rd_mux;
  reg mapped;
  reg auto_reg;
  reg drop_mon_reg;
  reg gate_reg;
  reg lo_reg;
  reg [`RHC_CFG_W-1:0] cfg_reg;
  reg [23:0] alo_reg;
  reg [15:0] ahi_reg;
  reg [7:0] tbuf_reg [0:6];
  reg [27:0] pwait_reg;
  reg pwr_ok_reg;
  reg [27:0] timer_reg;
  reg [2:0] job_reg;
  reg [1:0] step_reg;
  reg [2:0] xs_reg;
  reg [2:0] bidx_reg;
  reg wait_reg;
  reg abort_reg;
  reg power_on_flag_reg;
  reg nack_reg;
  reg late_reg;
  reg full_reg;
  reg irq_prev_reg;
  reg svc_pend_reg;
  reg eng_go_reg;
  reg [1:0] eng_cmd_reg;
  reg [7:0] eng_wdata_reg;
  reg eng_nack_reg;
  reg [3:0] d_idx;
  reg [2:0] d_len;
  reg d_rd;
  reg d_last;
  reg [7:0] wbyte;
  wire [2:0] sync_q;
  wire eng_done;
  wire eng_err;
  wire [7:0] eng_rdata;
  wire eng_scl_oe;
  wire eng_sda_oe;
  wire sda_s = sync_q[0];
  wire irq_a_s = sync_q[1];
  wire irq_b_s = sync_q[2];
  wire apb_acc = psel_in & penable_in & pready_reg;
  wire apb_wr = apb_acc & pwrite_in;
  wire wr_ctrl = apb_wr & (paddr_in == `RHC_OFS_CTRL);
  wire wr_stat = apb_wr & (paddr_in == `RHC_OFS_STAT);
  wire idle = (job_reg == J_NONE);
  wire can_go = idle & pwr_ok_reg;
  wire [4:0] cmds = pwdata_in[`RHC_C_CMDS];
  wire sw_go = can_go & wr_ctrl & (|cmds);
  wire irq_fall = irq_prev_reg & ~irq_a_s;
  wire last_byte = (bidx_reg == d_len - 3'h1);
  integer k;

  rhc_sync #(.W(3)) u_sync (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .d_in({irq_out_b_n_in, irq_out_a_n_in, sda_in}),
    .q_out(sync_q)
  );

  rhc_i2c_byte #(.QTR(SCL_QTR)) u_eng (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .go_in(eng_go_reg),
    .cmd_in(eng_cmd_reg),
    .wdata_in(eng_wdata_reg),
    .nack_in(eng_nack_reg),
    .done_out(eng_done),
    .ack_err_out(eng_err),
    .rdata_out(eng_rdata),
    .sda_in(sda_s),
    .scl_oe_out(eng_scl_oe),
    .sda_oe_out(eng_sda_oe)
  );

  function [7:0] ctl1_byte;
    input wen;
    input den;
    begin
      ctl1_byte = 8'h00;
      ctl1_byte[`RHC_F_CT] = cfg_reg[`RHC_F_CT];
      ctl1_byte[`RHC_B1_CLEN2] = cfg_reg[`RHC_F_CLEN2];
      ctl1_byte[`RHC_B1_WEEKLY_ALARM_ENABLE] = wen;
      ctl1_byte[`RHC_B1_DAILY_ALARM_ENABLE] = den;
    end
  endfunction

  // Flags written 1 are left untouched by the clock
  function [7:0] ctl2_byte;
    input vd;
    input ct;
    input wf;
    input df;
    begin
      ctl2_byte = 8'h00;
      ctl2_byte[`RHC_B2_SUPPLY_DROP_FLAG] = vd;
      ctl2_byte[`RHC_B2_CLEN1] = cfg_reg[`RHC_F_CLEN1];
      ctl2_byte[`RHC_B2_PERIODIC_IRQ_FLAG] = ct;
      ctl2_byte[`RHC_B2_WEEKLY_ALARM_FLAG] = wf;
      ctl2_byte[`RHC_B2_DAILY_ALARM_FLAG] = df;
    end
  endfunction

  // Transfer list of each job
  always @* begin
    d_idx = `RHC_R_CTL1;
    d_len = `RHC_LEN_ONE;
    d_rd = 1'b0;
    d_last = 1'b1;
    wbyte = 8'h00;
    case (job_reg)
      J_INIT: begin
        d_last = (step_reg == 2'h2);
        d_rd = (step_reg == 2'h0);
        if (step_reg == 2'h1) begin
          d_idx = `RHC_R_ADJ;
          wbyte = cfg_reg[`RHC_F_ADJ];
        end else begin
          wbyte = ctl1_byte(1'b0, 1'b0);
        end
      end
      J_SET: begin
        if (step_reg == 2'h0) begin
          d_idx = `RHC_R_SEC;
          d_len = `RHC_LEN_FULL;
          d_last = ~drop_mon_reg;
          wbyte = tbuf_reg[bidx_reg];
        end else begin
          d_idx = `RHC_R_CTL2;
          wbyte = ctl2_byte(1'b0, 1'b1, 1'b1, 1'b1);
        end
      end
      J_READ: begin
        d_idx = `RHC_R_SEC;
        d_len = `RHC_LEN_FULL;
        d_rd = 1'b1;
      end
      J_SVC: begin
        if (step_reg == 2'h0) begin
          d_idx = `RHC_R_SEC;
          d_len = full_reg ? `RHC_LEN_FULL : `RHC_LEN_RED;
          d_rd = 1'b1;
          d_last = 1'b0;
        end else begin
          d_idx = `RHC_R_CTL2;
          wbyte = ctl2_byte(1'b1, 1'b0, 1'b1, 1'b1);
        end
      end
      J_ALM: begin
        d_last = (step_reg == 2'h2);
        if (step_reg == 2'h1) begin
          d_idx = `RHC_R_ALW;
          d_len = `RHC_LEN_ALM;
          case (bidx_reg)
            3'h0: wbyte = alo_reg[7:0];
            3'h1: wbyte = alo_reg[15:8];
            3'h2: wbyte = alo_reg[23:16];
            3'h3: wbyte = ahi_reg[7:0];
            default: wbyte = ahi_reg[15:8];
          endcase
        end else if (step_reg == 2'h0) begin
          wbyte = ctl1_byte(1'b0, 1'b0);
        end else begin
          wbyte = ctl1_byte(cfg_reg[`RHC_F_WEN], cfg_reg[`RHC_F_DEN]);
        end
      end
      J_CLR: begin
        d_idx = `RHC_R_CTL2;
        wbyte = ctl2_byte(1'b1, 1'b1, ~cfg_reg[`RHC_F_CLRW], ~cfg_reg[`RHC_F_CLRD]);
      end
      default: d_last = 1'b1;
    endcase
  end

  // Sequencer, time buffer and status flags
  always @(posedge clock_in) begin
    if (!rst_b_in) begin
      for (k = 0; k < 7; k = k + 1)
        tbuf_reg[k] <= 8'h00;
      pwait_reg <= 28'h0000000;
      pwr_ok_reg <= 1'b0;
      timer_reg <= 28'h0000000;
      job_reg <= J_NONE;
      step_reg <= 2'h0;
      xs_reg <= X_START;
      bidx_reg <= 3'h0;
      wait_reg <= 1'b0;
      abort_reg <= 1'b0;
      power_on_flag_reg <= 1'b0;
      nack_reg <= 1'b0;
      late_reg <= 1'b0;
      full_reg <= 1'b0;
      irq_prev_reg <= 1'b1;
      svc_pend_reg <= 1'b0;
      eng_go_reg <= 1'b0;
      eng_cmd_reg <= `RHC_E_STOP;
      eng_wdata_reg <= 8'h00;
      eng_nack_reg <= 1'b0;
    end else begin
      eng_go_reg <= 1'b0;
      if (pwait_reg != PWR_WAIT_CYC)
        pwait_reg <= pwait_reg + 28'h0000001;
      else
        pwr_ok_reg <= 1'b1;
      irq_prev_reg <= irq_a_s;
      // Line is pulled up, so only the pull-down edge is an event
      if (irq_fall)
        svc_pend_reg <= 1'b1;
      if (wr_stat & pwdata_in[`RHC_S_NACK])
        nack_reg <= 1'b0;
      if (wr_stat & pwdata_in[`RHC_S_LATE])
        late_reg <= 1'b0;
      if (apb_wr & (paddr_in == `RHC_OFS_TLO))
        for (k = 0; k < 4; k = k + 1)
          tbuf_reg[k] <= pwdata_in[k*8 +: 8];
      if (apb_wr & (paddr_in == `RHC_OFS_THI))
        for (k = 0; k < 3; k = k + 1)
          tbuf_reg[k+4] <= pwdata_in[k*8 +: 8];
      if (idle) begin
        step_reg <= 2'h0;
        xs_reg <= X_START;
        bidx_reg <= 3'h0;
        wait_reg <= 1'b0;
        abort_reg <= 1'b0;
        timer_reg <= 28'h0000000;
        if (sw_go) begin
          job_reg <= cmds[`RHC_C_INIT] ? J_INIT : cmds[`RHC_C_SET] ? J_SET :
                     cmds[`RHC_C_READ] ? J_READ : cmds[`RHC_C_ALM] ? J_ALM : J_CLR;
        end else if (can_go & auto_reg & svc_pend_reg) begin
          job_reg <= J_SVC;
          svc_pend_reg <= irq_fall;
        end
      end else begin
        if (timer_reg != 28'hFFFFFFF)
          timer_reg <= timer_reg + 28'h0000001;
        if (xs_reg == X_END) begin
          // Counter steps are timed from job start, so an interrupt read is covered too
          if (d_idx == `RHC_R_SEC && timer_reg > LIMIT_CYC)
            late_reg <= 1'b1;
          if (!abort_reg && step_reg == 2'h0 && job_reg == J_SET)
            full_reg <= 1'b1;
          if (!abort_reg && step_reg == 2'h0 && job_reg == J_SVC && d_len == `RHC_LEN_FULL)
            full_reg <= 1'b0;
          if (abort_reg | d_last) begin
            job_reg <= J_NONE;
          end else begin
            step_reg <= step_reg + 2'h1;
            xs_reg <= X_START;
            bidx_reg <= 3'h0;
          end
        end else if (!wait_reg) begin
          wait_reg <= 1'b1;
          eng_go_reg <= 1'b1;
          eng_nack_reg <= last_byte;
          eng_cmd_reg <= `RHC_E_WR;
          case (xs_reg)
            X_START, X_RST: eng_cmd_reg <= `RHC_E_START;
            X_ADDRW: eng_wdata_reg <= {DEV_ADDR, 1'b0};
            X_ADDRR: eng_wdata_reg <= {DEV_ADDR, 1'b1};
            X_PTR: eng_wdata_reg <= {d_idx, 4'h0};
            X_DATA: begin
              eng_cmd_reg <= d_rd ? `RHC_E_RD : `RHC_E_WR;
              eng_wdata_reg <= wbyte;
            end
            default: eng_cmd_reg <= `RHC_E_STOP;
          endcase
        end else if (eng_done) begin
          wait_reg <= 1'b0;
          case (xs_reg)
            X_START: xs_reg <= X_ADDRW;
            X_RST: xs_reg <= X_ADDRR;
            X_ADDRW, X_PTR, X_ADDRR: begin
              if (eng_err) begin
                nack_reg <= 1'b1;
                abort_reg <= 1'b1;
                xs_reg <= X_STOP;
              end else if (xs_reg == X_ADDRW) begin
                xs_reg <= X_PTR;
              end else if (xs_reg == X_PTR && d_rd) begin
                xs_reg <= X_RST;
              end else begin
                xs_reg <= X_DATA;
              end
            end
            X_DATA: begin
              if (d_rd && job_reg == J_INIT)
                power_on_flag_reg <= eng_rdata[`RHC_B1_POWER_ON_FLAG];
              else if (d_rd)
                tbuf_reg[bidx_reg] <= eng_rdata;
              // No stop until the last byte of the burst, unless a written byte is not acknowledged
              if (!d_rd && eng_err) begin
                nack_reg <= 1'b1;
                abort_reg <= 1'b1;
                xs_reg <= X_STOP;
              end else if (last_byte) begin
                xs_reg <= X_STOP;
              end else begin
                bidx_reg <= bidx_reg + 3'h1;
              end
            end
            default: xs_reg <= X_END;
          endcase
        end
      end
    end
  end

  always @* begin
    mapped = 1'b1;
    case (paddr_in)
      `RHC_OFS_CTRL: rd_mux = {24'h000000, gate_reg, drop_mon_reg, auto_reg, 5'h00};
      `RHC_OFS_CFG: rd_mux = {11'h000, cfg_reg};
      `RHC_OFS_TLO: rd_mux = {tbuf_reg[3], tbuf_reg[2], tbuf_reg[1], tbuf_reg[0]};
      `RHC_OFS_THI: rd_mux = {8'h00, tbuf_reg[6], tbuf_reg[5], tbuf_reg[4]};
      `RHC_OFS_ALO: rd_mux = {8'h00, alo_reg};
      `RHC_OFS_AHI: rd_mux = {16'h0000, ahi_reg};
      `RHC_OFS_STAT: rd_mux = {24'h000000, irq_b_s, irq_a_s, full_reg, late_reg,
                               nack_reg, power_on_flag_reg, pwr_ok_reg, ~idle};
      default: begin
        rd_mux = 32'h00000000;
        mapped = 1'b0;
      end
    endcase
  end

  // APB slave: one wait state on every access
  always @(posedge clock_in) begin
    if (!rst_b_in) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
      auto_reg <= 1'b0;
      drop_mon_reg <= 1'b0;
      gate_reg <= 1'b1;
      lo_reg <= 1'b0;
      cfg_reg <= `RHC_CFG_RST;
      alo_reg <= 24'h000000;
      ahi_reg <= 16'h0000;
    end else begin
      lo_reg <= 1'b0;
      pready_reg <= psel_in & penable_in & ~pready_reg;
      if (psel_in & penable_in & ~pready_reg) begin
        pslverr_reg <= ~mapped;
        prdata_reg <= pwrite_in ? 32'h00000000 : rd_mux;
      end
      if (wr_ctrl) begin
        auto_reg <= pwdata_in[`RHC_C_AUTO];
        drop_mon_reg <= pwdata_in[`RHC_C_DROP_MON];
        gate_reg <= pwdata_in[`RHC_C_GATE];
      end
      if (apb_wr & (paddr_in == `RHC_OFS_CFG))
        cfg_reg <= pwdata_in[`RHC_CFG_W-1:0];
      if (apb_wr & (paddr_in == `RHC_OFS_ALO))
        alo_reg <= pwdata_in[23:0];
      if (apb_wr & (paddr_in == `RHC_OFS_AHI))
        ahi_reg <= pwdata_in[15:0];
    end
  end

  assign pready_out = pready_reg;
  assign prdata_out = prdata_reg;
  assign pslverr_out = pslverr_reg;
  assign scl_out = lo_reg;
  assign sda_out = lo_reg;
  assign scl_oe_out = eng_scl_oe;
  assign sda_oe_out = eng_sda_oe;
  assign clock_out_gate_pin_out = gate_reg;
endmodule

// ===== testbench/rhc_host_asserts.sv
`timescale 1ns/100ps
module rhc_host_chk #(
  parameter [27:0] PWR_WAIT_CYC = 28'hBEBC200
) (
  // Clock and reset
  input wire clock_in,
  input wire rst_b_in,
  // APB side
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [7:0] paddr_in,
  input wire [31:0] pwdata_in,
  input wire pready_out,
  input wire [31:0] prdata_out,
  input wire pslverr_out,
  // Link and gate
  input wire scl_out,
  input wire scl_oe_out,
  input wire sda_out,
  input wire sda_oe_out,
  input wire clock_out_gate_pin_out
);
  logic [27:0] up_cnt;
  always @(posedge clock_in) begin
    if (!rst_b_in) up_cnt <= 28'h0000000;
    else if (up_cnt != 28'hFFFFFFF) up_cnt <= up_cnt + 28'h0000001;
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  sequence s_wait; psel_in && penable_in && !pready_out; endsequence
  sequence s_ctrl_wr; pready_out && pwrite_in && paddr_in == 8'h00; endsequence
  property p_one_wait; s_wait |=> pready_out; endproperty
  property p_pulse; pready_out |=> !pready_out; endproperty
  property p_in_access; pready_out |-> psel_in && penable_in; endproperty
  property p_unmapped; pready_out && paddr_in > 8'h18 |-> pslverr_out && prdata_out == 32'h0;
  endproperty
  property p_cmd_zero; pready_out && !pwrite_in && paddr_in == 8'h00 |-> prdata_out[4:0] == 5'h0;
  endproperty
  property p_quiet; up_cnt < PWR_WAIT_CYC |-> !scl_oe_out && !sda_oe_out; endproperty
  property p_no_rdy;
    pready_out && paddr_in == 8'h18 && up_cnt < PWR_WAIT_CYC |-> !prdata_out[1];
  endproperty
  property p_gate; s_ctrl_wr |=> clock_out_gate_pin_out == $past(pwdata_in[7]); endproperty
  property p_low_only; scl_out == 1'b0 && sda_out == 1'b0; endproperty
  a_one_wait: assert property (p_one_wait) else $error("ready late");
  a_pulse: assert property (p_pulse) else $error("ready held");
  a_in_access: assert property (p_in_access) else $error("ready outside access");
  a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
  a_cmd_zero: assert property (p_cmd_zero) else $error("command bits read back");
  a_quiet: assert property (p_quiet) else $error("link used too early");
  a_no_rdy: assert property (p_no_rdy) else $error("ready flag too early");
  a_gate: assert property (p_gate) else $error("gate not following write");
  a_low_only: assert property (p_low_only) else $error("line driven high");
endmodule
bind rhc_host rhc_host_chk #(.PWR_WAIT_CYC(PWR_WAIT_CYC)) u_chk (.*);

// ===== testbench/rhc_rtc_model.sv
`timescale 1ns/100ps
module rhc_rtc_model #(
  parameter [6:0] ADDR = 7'h30,
  parameter SUB_N = 30000
) (
  input wire clock_in,
  input wire scl_in,
  input wire sda_in,
  output logic sda_pull_out,
  output wire irq_pull_out
);
  logic [7:0] mem [0:15];
  logic [7:0] sr, ob;
  logic [3:0] ptr;
  logic act, rd, snd, mute, en_seen;
  int bc, ph, cnt, rd_last, wr_max, sub, n_start;
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    mem[14] = 8'h20;
    {act, rd, snd, mute, en_seen, sda_pull_out} = '0;
    {bc, ph, cnt, rd_last, wr_max, sub, n_start} = '0;
  end
  // Open drain: the model only ever asks for a low level
  assign irq_pull_out = (mem[14][2] & mem[15][2]) | (mem[14][6] & mem[15][0]);
  always @(posedge clock_in) begin
    sub = (sub >= SUB_N) ? 0 : sub + 1;
    if (sub == 0) mem[15][2] = mem[15][2] | mem[14][2];
  end
  task automatic put(input logic [7:0] d);
    if (ptr == 4'hF) mem[15] = (d & 8'hB8) | (mem[15] & d & 8'h47);
    else mem[ptr] = d;
    if (ptr == 4'h0) sub = 0;
    if (ptr >= 4'h8 && ptr <= 4'hC) en_seen = en_seen | (|mem[14][7:6]);
    ptr = ptr + 4'h1;
  endtask
  always @(negedge sda_in) if (scl_in === 1'b1) begin
    {act, bc, ph, cnt, snd} = {!mute, 32'h0, 32'h0, 32'h0, 1'b0};
    n_start++;
  end
  always @(posedge sda_in) if (scl_in === 1'b1 && act) begin
    act = 0;
    if (rd) rd_last = cnt;
    else if (cnt > wr_max) wr_max = cnt;
  end
  always @(posedge scl_in) if (act) begin
    if (bc < 8) sr = {sr[6:0], sda_in};
    else if (snd && sda_in) snd = 0;
    bc = (bc == 8) ? 0 : bc + 1;
  end
  always @(negedge scl_in) if (act) begin
    sda_pull_out = 0;
    if (bc == 8 && ph == 0) begin
      {act, rd, snd} = {sr[7:1] == ADDR, sr[0], sr[0]};
      ph = sr[0] ? 2 : 1;
      sda_pull_out = act;
      ob = mem[ptr];
    end else if (bc == 8 && !rd) begin
      if (ph == 1) ptr = sr[7:4];
      else put(sr);
      if (ph == 2) cnt++;
      ph = 2;
      sda_pull_out = 1;
    end else if (bc == 8) begin
      cnt++;
      ptr = ptr + 4'h1;
      ob = mem[ptr];
    end else if (snd) sda_pull_out = !ob[7 - bc];
  end
endmodule

// ===== testbench/rhc_host_tb.sv
`timescale 1ns/100ps
module rhc_host_tb;
  logic clk = 0, rst_b = 0, psel = 0, pen = 0, pwr = 0, qe;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, q;
  logic [63:0] tv = 64'h0024110603124530;
  logic [39:0] av = 40'h0720031530;
  wire pready, pslverr, scl_oe, sda_oe, m_pull, irq_pull, gate;
  wire [31:0] prdata;
  wire scl_w = !scl_oe;
  wire sda_w = !(sda_oe | m_pull);
  int n_mismatch = 0, cmp_count = 0;
  always #5 clk = !clk;
  rhc_host #(.PWR_WAIT_CYC(28'h00000C8), .LIMIT_CYC(28'h00186A0), .SCL_QTR(16'h0004)) u_dut (
    .clock_in(clk), .rst_b_in(rst_b), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
    .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready), .prdata_out(prdata),
    .pslverr_out(pslverr), .scl_out(), .scl_oe_out(scl_oe), .sda_in(sda_w), .sda_out(),
    .sda_oe_out(sda_oe), .irq_out_a_n_in(!irq_pull), .irq_out_b_n_in(1'b1),
    .clock_out_gate_pin_out(gate));
  rhc_rtc_model u_rtc (.clock_in(clk), .scl_in(scl_w), .sda_in(sda_w),
    .sda_pull_out(m_pull), .irq_pull_out(irq_pull));
  task automatic final_report;
    if (n_mismatch == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) begin
      chk(1, 0);
      final_report;
    end
    q = prdata;
    qe = pslverr;
    psel <= 0;
    pen <= 0;
    @(posedge clk);
  endtask
  task automatic idle;
    int n;
    n = 0;
    do begin
      apb(0, 8'h18, 0);
      n++;
    end while (q[0] !== 1'b0 && n < 2000);
    if (n == 2000) begin
      chk(1, 0);
      final_report;
    end
  endtask
  task automatic wpull(input logic v);
    int n;
    n = 0;
    while (irq_pull !== v && n < 35000) begin
      @(posedge clk);
      n++;
    end
    if (n == 35000) begin
      chk(1, 0);
      final_report;
    end
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1;
    @(posedge clk);
    chk(gate, 1);
    apb(1, 8'h00, 32'h81);
    apb(0, 8'h18, 0);
    chk(q[1], 0);
    repeat (250) @(posedge clk);
    chk(u_rtc.n_start, 0);
    apb(1, 8'h04, 32'h00005A04);
    apb(1, 8'h00, 32'h81);
    idle;
    chk(q[7:2], 6'h31);
    chk(u_rtc.mem[7], 8'h5A);
    chk(u_rtc.mem[14] & 8'hC7, 8'h04);
    u_rtc.mem[15] = 8'h40;
    apb(1, 8'h08, tv[31:0]);
    apb(1, 8'h0C, tv[63:32]);
    apb(1, 8'h00, 32'hC2);
    idle;
    for (int i = 0; i < 7; i++) chk(u_rtc.mem[i], tv[8*i +: 8]);
    chk(u_rtc.wr_max, 7);
    chk(u_rtc.mem[15][6], 0);
    for (int i = 0; i < 7; i++) u_rtc.mem[i] = 8'h11 * i + 8'h10;
    apb(1, 8'h00, 32'h84);
    idle;
    apb(0, 8'h08, 0);
    chk(q, 32'h43322110);
    apb(0, 8'h0C, 0);
    chk(q, 32'h00766554);
    chk(u_rtc.rd_last, 7);
    apb(1, 8'h00, 32'hA0);
    for (int k = 0; k < 2; k++) begin
      wpull(1);
      wpull(0);
      idle;
      chk(u_rtc.rd_last, k ? 5 : 7);
      chk(u_rtc.mem[15][2], 0);
    end
    chk(q[4], 0);
    apb(1, 8'h00, 32'h80);
    u_rtc.mem[14][7:6] = 2'b11;
    apb(1, 8'h10, {8'h00, av[23:0]});
    apb(1, 8'h14, {16'h0000, av[39:24]});
    apb(1, 8'h04, 32'h00025A04);
    apb(1, 8'h00, 32'h88);
    idle;
    chk(u_rtc.en_seen, 0);
    for (int i = 0; i < 5; i++) chk(u_rtc.mem[8 + i], av[8*i +: 8]);
    chk(u_rtc.mem[14][7:6], 2'b10);
    u_rtc.mem[15][1:0] = 2'b11;
    apb(1, 8'h04, 32'h000A5A04);
    apb(1, 8'h00, 32'h90);
    idle;
    chk(u_rtc.mem[15][1:0], 2'b01);
    apb(0, 8'h40, 0);
    chk({qe, q[30:0]}, 32'h80000000);
    apb(0, 8'h00, 0);
    chk(q[4:0], 0);
    u_rtc.mute = 1;
    apb(1, 8'h00, 32'h84);
    idle;
    chk(q[3], 1);
    apb(1, 8'h18, 32'h08);
    apb(0, 8'h18, 0);
    chk(q[3], 0);
    apb(1, 8'h00, 32'h00);
    chk(gate, 0);
    final_report;
  end
endmodule
